// ==== dcp_cfg.svh ====
// Offsets, field positions and reset values of the dummy-cycle pattern table.
`ifndef DCP_CFG_SVH
`define DCP_CFG_SVH

`define DCP_ADDR_W      8
`define DCP_OFF_WORD9   8'h20
`define DCP_OFF_WORD10  8'h24
`define DCP_PAT_W       5
`define DCP_FIELD_W     6
`define DCP_ENTRIES     6
`define DCP_W9_ENTRIES  5
`define DCP_FIELD_TOP   31
`define DCP_RSVD_MSB    1
`define DCP_W10_LOW_MSB 25
`define DCP_ENTRY_RST   6'h00

`endif

// ==== dcp_pkg.sv ====
// Types shared by the dummy-cycle pattern table.
`include "dcp_cfg.svh"

package dcp_pkg;

  // One latency entry: availability flag and the pattern that selects it.
  typedef struct packed {
    logic                    supported;
    logic [`DCP_PAT_W-1:0]   pattern;
  } dcp_entry_type;

endpackage

// ==== dcp_dummy_cycle_table.sv ====
// Register view of the variable dummy-cycle support flags and selecting patterns.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ns
`include "dcp_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Word nine bit 31 shows whether 20 dummy cycles are available, bits 30 to 26 its pattern.
// - Word nine bit 25 shows whether 18 dummy cycles are available, bits 24 to 20 its pattern.
// - Word nine bit 19 shows whether 16 dummy cycles are available, bits 18 to 14 its pattern.
// - Word nine bit 13 shows whether 14 dummy cycles are available, bits 12 to 8 its pattern.
// - Word nine bit 7 shows whether 12 dummy cycles are available, bits 6 to 2 its pattern.
// - Word nine bits 1 and 0 are reserved and always read as zero.
// - Word ten bit 31 shows whether 10 dummy cycles are available, bits 30 to 26 its pattern.
// - A pattern narrower than five bits sits in the low positions with zero above it.
module dcp_dummy_cycle_table
  import dcp_pkg::*;
#(
  parameter int PAT_BITS = `DCP_PAT_W
) (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic [`DCP_ADDR_W-1:0]   address,
  input  wire logic [31:0]              writeData,
  input  wire logic                     writeStrobe,
  input  wire logic                     readStrobe,
  output logic      [31:0]              readData,
  output logic      [`DCP_ENTRIES-1:0]  supportFlags
);

  // A wider pattern has no field to live in, and zero bits could select nothing.
  if (PAT_BITS < 1 || PAT_BITS > `DCP_PAT_W) begin : gBadPatBits
    $error("PAT_BITS must lie between 1 and 5");
  end

  // Physical latency bits the device really has; the bits above are forced to zero.
  localparam logic [`DCP_PAT_W-1:0] PAT_MASK = ~(5'h1F << PAT_BITS);

  ////////////////////////////////////////////////////////////////////////////////
  // Field extraction, used for both table words.

  function automatic dcp_entry_type fieldFromWord(input logic [31:0] word, input int top);
    dcp_entry_type e;
    e.supported = word[top];
    e.pattern   = word[top-1 -: `DCP_PAT_W] & PAT_MASK;
    return e;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Table entries: index 0 is 20 cycles, stepping down by two to index 5 at 10 cycles.

  dcp_entry_type entry_reg  [`DCP_ENTRIES];
  dcp_entry_type entry_next [`DCP_ENTRIES];

  always_comb begin
    for (int i = 0; i < `DCP_ENTRIES; i++) begin
      entry_next[i] = entry_reg[i];
    end
    if (writeStrobe && address == `DCP_OFF_WORD9) begin
      for (int i = 0; i < `DCP_W9_ENTRIES; i++) begin
        entry_next[i] = fieldFromWord(writeData, `DCP_FIELD_TOP - `DCP_FIELD_W * i);
      end
    end else if (writeStrobe && address == `DCP_OFF_WORD10) begin
      entry_next[`DCP_W9_ENTRIES] = fieldFromWord(writeData, `DCP_FIELD_TOP);
    end
  end

  // Every entry starts as not supported, so a host never trusts a pattern
  // that software has not written yet.
  always_ff @(posedge clock) begin
    for (int i = 0; i < `DCP_ENTRIES; i++) begin
      if (rst) begin
        entry_reg[i] <= `DCP_ENTRY_RST;
      end else begin
        entry_reg[i] <= entry_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path. Data stand only in the cycle after the strobe, zero otherwise,
  // so a stale word can never be mistaken for a fresh answer.

  logic [31:0]             word9;
  logic [31:0]             word10;
  logic [31:0]             readData_reg;
  logic [31:0]             readData_next;
  logic [`DCP_ENTRIES-1:0] supportFlags_reg;
  logic [`DCP_ENTRIES-1:0] supportFlags_next;

  always_comb begin
    word9  = '0;
    word10 = '0;
    for (int i = 0; i < `DCP_W9_ENTRIES; i++) begin
      word9[`DCP_FIELD_TOP - `DCP_FIELD_W * i -: `DCP_FIELD_W] = entry_reg[i];
    end
    word10[`DCP_FIELD_TOP -: `DCP_FIELD_W] = entry_reg[`DCP_W9_ENTRIES];
    readData_next = '0;
    if (readStrobe && address == `DCP_OFF_WORD9) begin
      readData_next = word9;
    end else if (readStrobe && address == `DCP_OFF_WORD10) begin
      readData_next = word10;
    end
    // Taken from the next table values, so a flag never runs a cycle behind
    // the pattern that it qualifies.
    for (int i = 0; i < `DCP_ENTRIES; i++) begin
      supportFlags_next[`DCP_ENTRIES-1-i] = entry_next[i].supported;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      readData_reg     <= 32'h00000000;
      supportFlags_reg <= 6'h00;
    end else begin
      readData_reg     <= readData_next;
      supportFlags_reg <= supportFlags_next;
    end
  end

  assign readData     = readData_reg;
  assign supportFlags = supportFlags_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // One word written and read back in the very next cycle.
  sequence sWriteRead9;
    writeStrobe && address == `DCP_OFF_WORD9 ##1 readStrobe && address == `DCP_OFF_WORD9;
  endsequence

  sequence sWriteRead10;
    writeStrobe && address == `DCP_OFF_WORD10 ##1 readStrobe && address == `DCP_OFF_WORD10;
  endsequence

  sequence sReadTen;
    readStrobe && address == `DCP_OFF_WORD10;
  endsequence

  sequence sReadUnmapped;
    readStrobe && address != `DCP_OFF_WORD9 && address != `DCP_OFF_WORD10;
  endsequence

  sequence sWriteUnmapped;
    writeStrobe && address != `DCP_OFF_WORD9 && address != `DCP_OFF_WORD10;
  endsequence

  a_flag_20_cycles: assert property (sWriteRead9 |=> readData[31] == $past(writeData[31], 2))
    else $error("20-cycle flag does not read back as written");
  a_pattern_18_cycles: assert property (sWriteRead9 |=>
      readData[24:20] == ($past(writeData[24:20], 2) & PAT_MASK))
    else $error("18-cycle pattern does not read back as written");
  a_flag_16_cycles: assert property (sWriteRead9 |=>
      readData[19:14] == {$past(writeData[19], 2), $past(writeData[18:14], 2) & PAT_MASK})
    else $error("16-cycle field does not read back as written");
  a_field_14_cycles: assert property (sWriteRead9 |=>
      readData[13:8] == {$past(writeData[13], 2), $past(writeData[12:8], 2) & PAT_MASK})
    else $error("14-cycle field does not read back as written");
  a_field_12_cycles: assert property (sWriteRead9 |=>
      readData[7:2] == {$past(writeData[7], 2), $past(writeData[6:2], 2) & PAT_MASK})
    else $error("12-cycle field does not read back as written");
  a_reserved_zero: assert property (readStrobe && address == `DCP_OFF_WORD9 |=>
      readData[`DCP_RSVD_MSB:0] == 2'h0)
    else $error("reserved bits of word nine are not zero");
  a_field_10_cycles: assert property (sWriteRead10 |=>
      readData[31:26] == {$past(writeData[31], 2), $past(writeData[30:26], 2) & PAT_MASK}
      && readData[`DCP_W10_LOW_MSB:0] == 26'h0)
    else $error("10-cycle field does not read back as written");
  a_pattern_upper_zero: assert property (readStrobe |=>
      (readData[30:26] & ~PAT_MASK) == 5'h00 && (readData[24:20] & ~PAT_MASK) == 5'h00)
    else $error("unused pattern bits are not zero");
  a_idle_read_zero: assert property (!readStrobe |=> readData == 32'h00000000)
    else $error("read data stand outside the answer cycle");
  a_flags_follow_table: assert property (sWriteRead9 |->
      supportFlags[5] == $past(writeData[31]))
    else $error("support flag output disagrees with the table");

  // Flags of the lower entries and of word ten follow the same write edge as the table.
  a_flags_lower_table: assert property (sWriteRead9 |->
      supportFlags[4:1] == {$past(writeData[25]), $past(writeData[19]),
                            $past(writeData[13]), $past(writeData[7])})
    else $error("lower support flags disagree with the table");
  a_flag_word_ten: assert property (sWriteRead10 |->
      supportFlags[0] == $past(writeData[31]))
    else $error("10-cycle support flag disagrees with the table");
  a_ten_keeps_nine: assert property (sWriteRead10 |->
      supportFlags[5:1] == $past(supportFlags[5:1]))
    else $error("write to word ten disturbs the flags of word nine");

  // Field read-back for the parts that the checks above leave out.
  a_pattern_20_cycles: assert property (sWriteRead9 |=>
      readData[30:26] == ($past(writeData[30:26], 2) & PAT_MASK))
    else $error("20-cycle pattern does not read back as written");
  a_flag_18_cycles: assert property (sWriteRead9 |=>
      readData[25] == $past(writeData[25], 2))
    else $error("18-cycle flag does not read back as written");
  a_ten_low_zero: assert property (sReadTen |=>
      readData[`DCP_W10_LOW_MSB:0] == 26'h0000000)
    else $error("unused bits of word ten are not zero");
  a_lower_pattern_zero: assert property (readStrobe |=>
      (readData[18:14] & ~PAT_MASK) == 5'h00 && (readData[12:8] & ~PAT_MASK) == 5'h00
      && (readData[6:2] & ~PAT_MASK) == 5'h00)
    else $error("unused pattern bits of the lower entries are not zero");
  a_unmapped_read_zero: assert property (sReadUnmapped |=>
      readData == 32'h00000000)
    else $error("read of an unmapped address does not return zero");

  // The flags are a level that software may poll at any time, so they must only
  // move on a write to a table word or on reset.
  a_flags_hold: assert property (!writeStrobe |=> $stable(supportFlags))
    else $error("support flags change without a write");
  a_unmapped_write_ignored: assert property (sWriteUnmapped |=>
      $stable(supportFlags))
    else $error("write to an unmapped address changes the support flags");

  // This check must stay alive while reset is high, so it overrides the default disable.
  a_reset_clears: assert property (disable iff (1'b0) rst |=>
      readData == 32'h00000000 && supportFlags == 6'h00)
    else $error("reset does not clear the outputs");

endmodule

// ==== dcp_host_model.sv ====
// Host-side model that picks a latency pattern only where its flag allows it.
`timescale 1ns/1ns
module dcp_host_model (
  input  wire logic [31:0] wordNine,
  input  wire logic [2:0]  wantIndex,
  output logic             pickOk,
  output logic [4:0]       pickPattern
);
  // A pattern beside a clear flag is never used, so it is handed on as zero.
  always_comb begin
    pickOk = wordNine[31 - 6 * wantIndex];
    pickPattern = pickOk ? wordNine[30 - 6 * wantIndex -: 5] : 5'h00;
  end
endmodule

// ==== dcp_dummy_cycle_table_tb_top.sv ====
// Self-checking bench for the dummy-cycle pattern table.
`timescale 1ns/1ns
module dcp_dummy_cycle_table_tb_top;
  logic        clock = 1'b0, rst = 1'b1, writeStrobe = 1'b0, readStrobe = 1'b0;
  logic [7:0]  address = 8'h00;
  logic [31:0] writeData = 32'h0, readData, hostWord = 32'h0, v;
  logic [5:0]  supportFlags;
  logic [2:0]  wantIndex = 3'h0;
  logic        pickOk;
  logic [4:0]  pickPattern;
  int          mismatches = 0, comparisons = 0, cycles = 0;
  always #25 clock = ~clock;
  // Three physical bits make the masking of the upper pattern bits visible.
  dcp_dummy_cycle_table #(.PAT_BITS(3)) i_dut (.clock(clock), .rst(rst), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData), .supportFlags(supportFlags));
  dcp_host_model i_host (.wordNine(hostWord), .wantIndex(wantIndex), .pickOk(pickOk),
    .pickPattern(pickPattern));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a; writeData <= d; writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    address <= a; readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 v = readData;
  endtask
  // A write followed by a read of the same word with no gap between the strobes.
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 v = readData;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_flags;
    for (int i = 0; i < 5; i++) begin
      wr_rd(8'h20, 32'h1 << (31 - 6 * i));
      chk("flags", {26'h0, supportFlags}, 32'h1 << (5 - i));
      chk("word nine", v, 32'h1 << (31 - 6 * i));
    end
    wr(8'h24, 32'h80000000);
    chk("flag ten", {26'h0, supportFlags}, 32'h03);
  endtask
  task automatic t_full;
    wr_rd(8'h20, 32'hFFFFFFFF);
    chk("nine full", v, 32'h9E79E79C);
    wr_rd(8'h24, 32'hFFFFFFFF);
    chk("ten full", v, 32'h9C000000);
    wr(8'h28, 32'hFFFFFFFF);
    rd(8'h28);
    chk("unmapped", v, 32'h0);
    rd(8'h24);
    chk("ten kept", v, 32'h9C000000);
    @(posedge clock);
    #1 chk("read drops", readData, 32'h0);
  endtask
  task automatic t_reset;
    wr_rd(8'h20, 32'hFFFFFFFF);
    wr_rd(8'h24, 32'hFFFFFFFF);
    chk("flags set", {26'h0, supportFlags}, 32'h3F);
    repeat (2) @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(8'h20);
    chk("nine cleared", v, 32'h0);
    chk("flags cleared", {26'h0, supportFlags}, 32'h0);
    rd(8'h24);
    chk("ten cleared", v, 32'h0);
  endtask
  task automatic t_host;
    wr_rd(8'h20, 32'h16300000);
    hostWord = v;
    #1 chk("clear flag", {26'h0, pickOk, pickPattern}, 32'h0);
    wantIndex = 3'h1;
    #1 chk("set flag", {26'h0, pickOk, pickPattern}, 32'h23);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd(8'h20);
    chk("reset nine", v, 32'h0);
    chk("reset flags", {26'h0, supportFlags}, 32'h0);
    t_flags();
    t_full();
    t_host();
    t_reset();
    close_out();
  end
endmodule
